// ---- dv/fast_host_uart_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module fast_host_uart_bench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic sfr_write = 1'b0;
    logic sfr_read = 1'b0;
    logic [7:0] sfr_rdata;
    logic rx_line;
    logic tx_line;
    logic wake_request;
    logic [7:0] b;
    int bad_count = 0;
    int check_count = 0;
    always #20 clk = ~clk;
    fast_host_uart fast_host_uart_i (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_rdata(sfr_rdata), .rx_line(rx_line),
        .tx_line(tx_line), .wake_request(wake_request));
    host_model host_model_i (.clk(clk), .rx_line(rx_line), .tx_line(tx_line));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_write = 1'b1;
        @(posedge clk) #1;
        sfr_write = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk) #1;
        sfr_addr = a;
        sfr_read = 1'b1;
        @(posedge clk) #1;
        sfr_read = 1'b0;
        chk(sfr_rdata & m, e);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #1_000_000;
        bad_count++;
        results;
    end
    task automatic t_regs;
        rd(8'hAE, 8'hFF, 8'hD8);
        rd(8'hAD, 8'hFF, 8'h00);
        rd(8'hA7, 8'hFF, 8'h00);
        wr(8'hAE, 8'h07);
        rd(8'hAC, 8'hFF, 8'h00);
        $display("regs done");
    endtask
    task automatic t_duplex;
        fork
            host_model_i.send(8'h3C, 1'b1);
            begin
                wr(8'hA2, 8'hA5);
                host_model_i.get(b);
            end
        join
        chk(b, 8'hA5);
        rd(8'hA2, 8'hFF, 8'h3C);
        $display("duplex done");
    endtask
    task automatic t_filter;
        logic [39:0] p = 40'h77FF000011;
        wr(8'hAC, 8'h03);
        for (int i = 0; i < 40; i += 8) begin
            host_model_i.send(p[i +: 8], 1'b1);
        end
        rd(8'hA2, 8'hFF, 8'h77);
        rd(8'hA2, 8'hFF, 8'h00);
        chk({7'h00, wake_request}, 8'h01);
        wr(8'hAC, 8'h02);
        chk({7'h00, wake_request}, 8'h00);
        $display("filter done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        #1 reset = 1'b0;
        t_regs;
        t_duplex;
        t_filter;
        results;
    end
endmodule
`default_nettype wire

// ---- dv/fast_host_uart_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module fast_host_uart_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_write,
    input wire logic sfr_read,
    input wire logic [7:0] sfr_rdata,
    input wire logic rx_line,
    input wire logic tx_line,
    input wire logic wake_request
);
    logic [7:0] cnt_q;
    logic [3:0] exp_q;
    wire rd_cnt = sfr_read && sfr_addr == 8'hAE;
    wire rd_pre = sfr_read && sfr_addr == 8'hAD;
    wire rd_ctl = sfr_read && sfr_addr == 8'hAC;
    wire wake_clr = sfr_write && sfr_addr == 8'hAC && sfr_wdata[1];
    wire bit8 = exp_q == 4'h0 && cnt_q == 8'h07;
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= 8'hD8;
            exp_q <= 4'h0;
        end else if (sfr_write && sfr_addr == 8'hAE) begin
            cnt_q <= sfr_wdata;
        end else if (sfr_write && sfr_addr == 8'hAD) begin
            exp_q <= sfr_wdata[3:0];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_low_bit; (!tx_line) [*8]; endsequence
    sequence s_wake_off; (!wake_request) [*4]; endsequence
    property p_hold; !sfr_read |=> $stable(sfr_rdata); endproperty
    property p_unmapped; sfr_read && sfr_addr == 8'hA7 |=> sfr_rdata == 8'h00; endproperty
    property p_ctl; rd_ctl |=> sfr_rdata[1:0] == 2'h0 && sfr_rdata[7:5] == 3'h0; endproperty
    property p_pre; rd_pre |=> sfr_rdata == {4'h0, exp_q}; endproperty
    property p_cnt; rd_cnt |=> sfr_rdata == cnt_q; endproperty
    property p_wake_hold; wake_request && !wake_clr |=> wake_request; endproperty
    property p_wake_clear; wake_clr |=> ##1 s_wake_off; endproperty
    property p_low_run; $fell(tx_line) && bit8 |-> s_low_bit; endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    a_ctl: assert property (p_ctl) else $error("control readback");
    a_pre: assert property (p_pre) else $error("prescale readback");
    a_cnt: assert property (p_cnt) else $error("counter readback");
    a_wake_hold: assert property (p_wake_hold) else $error("wake request dropped");
    a_wake_clear: assert property (p_wake_clear) else $error("wake not cleared");
    a_low_run: assert property (p_low_run) else $error("transmit bit short");
endmodule
bind fast_host_uart fast_host_uart_checker fast_host_uart_checker_i (.clk(clk), .reset(reset),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_write(sfr_write), .sfr_read(sfr_read),
    .sfr_rdata(sfr_rdata), .rx_line(rx_line), .tx_line(tx_line), .wake_request(wake_request));
`default_nettype wire

// ---- dv/host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model #(parameter int BIT = 8) (
    input wire logic clk,
    output logic rx_line,
    input wire logic tx_line
);
    initial rx_line = 1'b1;
    task automatic send(input logic [7:0] b, input logic stop);
        logic [10:0] f;
        f = {1'b1, stop, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rx_line = f[i];
            repeat (BIT) @(posedge clk);
            #1;
        end
    endtask
    task automatic get(output logic [7:0] b);
        @(negedge tx_line);
        repeat (BIT / 2) @(negedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(negedge clk);
            b[i] = tx_line;
        end
    endtask
endmodule
`default_nettype wire

// ---- rtl/fast_host_uart.sv ----
// Contract
// [RULE_01] Transmit and receive run independently, sending while receiving.
// [RULE_02] Bytes arriving while the receive FIFO is full are dropped.
// [RULE_03] Writing the FIFO data port loads transmit; reading returns received data.
// [RULE_04] A low level on the receive line starts a character.
// [RULE_05] Eight data bits per character, least significant bit first.
// [RULE_06] Receive stop bits must sample high; one or two are expected.
// [RULE_07] Transmit sends one to four stop bits after the data.
// [RULE_08] The link supports bit rates up to 1.288 Mbit/s.
// [RULE_09] All bit timing derives from the reference clock.
// [RULE_10] A power-of-two prescaler, factors 1 to 256, feeds the counter.
// [RULE_11] Prescaler and counter set bit length and sampling instant.
// [RULE_12] Armed preamble filter withholds bytes until 00 00 FF, then forwards.
// [RULE_13] Writing frame restart re-arms the filter; otherwise all bytes pass.
// [RULE_14] A 3-bit counter counts rising edges of the receive line.
// [RULE_15] At a count of five the wake-up request goes high.
// [RULE_16] Writing one to the wake enable bit clears the edge counter.
// [RULE_17] A holding buffer lets reception continue while a byte is stored.
// [RULE_18] Receive FIFO size is programmable up to 182; rest is transmit.
// [RULE_19] A low stop bit flags a framing error and drops the byte.
// [RULE_20] Each received bit is sampled near its middle.
// [RULE_21] The start bit is rechecked at mid-bit to reject glitches.
`timescale 1ns/1ps
`default_nettype none

module fast_host_uart (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Special-function register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_write,
    input wire logic sfr_read,
    output logic [7:0] sfr_rdata,
    // Serial link
    input wire logic rx_line,
    output logic tx_line,
    // Power management
    output logic wake_request
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic hit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
        return strobe && addr == target;
    endfunction

    function automatic logic [7:0] rx_next(input logic [7:0] ptr, input logic [7:0] size);
        return (ptr == size - 8'h01) ? 8'h00 : ptr + 8'h01;
    endfunction

    function automatic logic [7:0] tx_next(input logic [7:0] ptr, input logic [7:0] size);
        return (ptr == fast_uart_pkg::RAM_LAST) ? size : ptr + 8'h01;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    fast_uart_pkg::control_t control;
    fast_uart_pkg::baud_t baud;
    logic [7:0] receive_fifo_size;
    logic [7:0] fifo_mem [0:255];
    logic [7:0] rx_wr;
    logic [7:0] rx_rd;
    logic [7:0] rx_count;
    logic [7:0] tx_wr;
    logic [7:0] tx_rd;
    logic [8:0] tx_count;
    logic hold_valid;
    logic [7:0] hold_data;
    logic filter_armed;
    logic [1:0] pre_match;
    logic frame_error;
    logic overrun;
    logic [2:0] wake_count;
    logic rx_prev;
    logic tx_start;
    logic [7:0] tx_byte;
    logic tx_busy;
    logic rx_busy;
    logic rx_valid;
    fast_uart_pkg::rx_result_t rx_result;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    wire logic wr_data = hit(sfr_write, sfr_addr, fast_uart_pkg::ADDR_FIFO_DATA);
    wire logic rd_data = hit(sfr_read, sfr_addr, fast_uart_pkg::ADDR_FIFO_DATA);
    wire logic wr_size = hit(sfr_write, sfr_addr, fast_uart_pkg::ADDR_RX_SIZE);
    wire logic rd_status = hit(sfr_read, sfr_addr, fast_uart_pkg::ADDR_STATUS);
    wire logic wr_control = hit(sfr_write, sfr_addr, fast_uart_pkg::ADDR_CONTROL);
    wire logic wr_prescale = hit(sfr_write, sfr_addr, fast_uart_pkg::ADDR_PRESCALE);
    wire logic wr_counter = hit(sfr_write, sfr_addr, fast_uart_pkg::ADDR_COUNTER);
    wire fast_uart_pkg::control_t control_in = fast_uart_pkg::control_t'(sfr_wdata);
    wire logic restart_frame = wr_control && control_in.start_frame;
    wire logic wake_clear = wr_control && control_in.wake_enable_bit;

    // ------------------------------------------------------------------
    // FIFO occupancy
    // ------------------------------------------------------------------
    wire logic [8:0] tx_capacity = fast_uart_pkg::RAM_DEPTH - {1'b0, receive_fifo_size}; // see [RULE_18]
    wire logic rx_full = rx_count == receive_fifo_size;
    wire logic rx_empty = rx_count == 8'h00;
    wire logic tx_full = tx_count == tx_capacity;
    wire logic rx_store = hold_valid && !rx_full;
    wire logic rx_lost = hold_valid && rx_full; // see [RULE_02]
    wire logic rx_pop = rd_data && !rx_empty;
    wire logic tx_push = wr_data && !tx_full;
    wire logic [7:0] size_in = (sfr_wdata > fast_uart_pkg::RX_SIZE_MAX) ? fast_uart_pkg::RX_SIZE_MAX : sfr_wdata;

    // ------------------------------------------------------------------
    // Preamble filter
    // ------------------------------------------------------------------
    wire logic rx_good = rx_valid && !rx_result.frame_error; // see [RULE_19]
    wire logic is_zero = rx_result.data == fast_uart_pkg::PREAMBLE_ZERO;
    wire logic preamble_done = pre_match == fast_uart_pkg::PREAMBLE_ZEROS_SEEN
                               && rx_result.data == fast_uart_pkg::PREAMBLE_END;
    wire logic forward = rx_good && !filter_armed; // see [RULE_12], [RULE_13]
    wire logic [1:0] next_pre_match = !is_zero ? 2'h0
                                    : (pre_match == fast_uart_pkg::PREAMBLE_ZEROS_SEEN) ? pre_match
                                    : pre_match + 2'h1;

    // ------------------------------------------------------------------
    // Wake-up edge counter
    // ------------------------------------------------------------------
    wire logic rx_rise = rx_line && !rx_prev;
    wire logic wake_saturated = wake_count == fast_uart_pkg::WAKE_EDGES;
    wire logic [2:0] next_wake_count = wake_clear ? {2'b00, rx_rise} // see [RULE_16]
                                     : (rx_rise && !wake_saturated) ? wake_count + 3'h1 // see [RULE_14]
                                     : wake_count;

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------
    wire fast_uart_pkg::status_t status = '{
        tx_full: tx_full,
        rx_empty: rx_empty,
        filter_armed: filter_armed,
        wake_request: wake_request,
        rx_busy: rx_busy,
        tx_busy: tx_busy,
        overrun: overrun,
        frame_error: frame_error
    };
    wire logic [7:0] read_value =
        (sfr_addr == fast_uart_pkg::ADDR_FIFO_DATA) ? (rx_empty ? 8'h00 : fifo_mem[rx_rd]) // see [RULE_03]
      : (sfr_addr == fast_uart_pkg::ADDR_RX_SIZE) ? receive_fifo_size
      : (sfr_addr == fast_uart_pkg::ADDR_STATUS) ? status
      : (sfr_addr == fast_uart_pkg::ADDR_CONTROL) ? (control & fast_uart_pkg::CONTROL_STORED_MASK)
      : (sfr_addr == fast_uart_pkg::ADDR_PRESCALE) ? {4'h0, baud.exp}
      : (sfr_addr == fast_uart_pkg::ADDR_COUNTER) ? baud.count
      : 8'h00;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // The clock is the bit-timing reference; prescale and count select rates up to 1.288 Mbit/s.
    always_ff @(posedge clk) begin
        if (reset) begin
            control <= fast_uart_pkg::control_t'(fast_uart_pkg::CONTROL_RESET);
            baud <= '{exp: fast_uart_pkg::PRESCALE_RESET, count: fast_uart_pkg::COUNTER_RESET};
            receive_fifo_size <= fast_uart_pkg::RX_SIZE_RESET;
        end else begin
            if (wr_control) begin
                control <= control_in;
            end
            if (wr_prescale) begin
                baud.exp <= sfr_wdata[3:0]; // see [RULE_09], [RULE_10]
            end
            if (wr_counter) begin
                baud.count <= sfr_wdata; // see [RULE_08], [RULE_11]
            end
            if (wr_size) begin
                receive_fifo_size <= size_in; // see [RULE_18]
            end
        end
    end

    // ------------------------------------------------------------------
    // Shared FIFO memory
    // ------------------------------------------------------------------
    // Receive and transmit regions never overlap, so both writes can land in one cycle.
    always_ff @(posedge clk) begin
        if (rx_store) begin
            fifo_mem[rx_wr] <= hold_data;
        end
        if (tx_push) begin
            fifo_mem[tx_wr] <= sfr_wdata; // see [RULE_03]
        end
    end

    // A size write flushes both FIFOs because their regions move.
    always_ff @(posedge clk) begin
        if (reset || wr_size) begin
            rx_wr <= 8'h00;
            rx_rd <= 8'h00;
            rx_count <= 8'h00;
            tx_wr <= reset ? fast_uart_pkg::RX_SIZE_RESET : size_in;
            tx_rd <= reset ? fast_uart_pkg::RX_SIZE_RESET : size_in;
            tx_count <= 9'h000;
        end else begin
            if (rx_store) begin
                rx_wr <= rx_next(rx_wr, receive_fifo_size);
            end
            if (rx_pop) begin
                rx_rd <= rx_next(rx_rd, receive_fifo_size);
            end
            rx_count <= rx_count + {7'h00, rx_store} - {7'h00, rx_pop};
            if (tx_push) begin
                tx_wr <= tx_next(tx_wr, receive_fifo_size);
            end
            if (tx_start) begin
                tx_rd <= tx_next(tx_rd, receive_fifo_size);
            end
            tx_count <= tx_count + {8'h00, tx_push} - {8'h00, tx_start};
        end
    end

    // ------------------------------------------------------------------
    // Transmit feed
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_start <= 1'b0;
            tx_byte <= 8'h00;
        end else begin
            tx_start <= !tx_start && !tx_busy && tx_count != 9'h000 && !wr_size; // see [RULE_01]
            tx_byte <= fifo_mem[tx_rd];
        end
    end

    // ------------------------------------------------------------------
    // Receive holding buffer, filter and flags
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            hold_valid <= 1'b0;
            hold_data <= 8'h00;
            filter_armed <= 1'b0;
            pre_match <= 2'h0;
            frame_error <= 1'b0;
            overrun <= 1'b0;
        end else begin
            hold_valid <= forward; // see [RULE_17]
            if (forward) begin
                hold_data <= rx_result.data;
            end
            if (restart_frame) begin
                filter_armed <= 1'b1; // see [RULE_13]
                pre_match <= 2'h0;
            end else if (rx_good && filter_armed) begin
                filter_armed <= !preamble_done; // see [RULE_12]
                pre_match <= next_pre_match;
            end
            // A new event wins over the clear-on-read of the status register.
            frame_error <= (rx_valid && rx_result.frame_error) || (frame_error && !rd_status); // see [RULE_19]
            overrun <= rx_lost || (overrun && !rd_status); // see [RULE_02]
        end
    end

    // ------------------------------------------------------------------
    // Wake-up generator and read port
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_prev <= 1'b1;
            wake_count <= 3'h0;
            wake_request <= 1'b0;
            sfr_rdata <= 8'h00;
        end else begin
            rx_prev <= rx_line;
            wake_count <= next_wake_count;
            wake_request <= next_wake_count == fast_uart_pkg::WAKE_EDGES; // see [RULE_15]
            sfr_rdata <= sfr_read ? read_value : sfr_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Serial engines
    // ------------------------------------------------------------------
    uart_tx_engine tx_engine (
        .clk(clk),
        .reset(reset),
        .baud(baud),
        .stop_extra(control.tx_stop_extra),
        .start(tx_start),
        .data(tx_byte),
        .line(tx_line),
        .busy(tx_busy)
    );

    uart_rx_engine rx_engine (
        .clk(clk),
        .reset(reset),
        .baud(baud),
        .two_stops(control.rx_two_stops),
        .line(rx_line),
        .valid(rx_valid),
        .result(rx_result),
        .busy(rx_busy)
    );

endmodule

`default_nettype wire

// ---- rtl/fast_uart_pkg.sv ----
package fast_uart_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_FIFO_DATA = 8'hA2;
    localparam logic [7:0] ADDR_RX_SIZE = 8'hA3;
    localparam logic [7:0] ADDR_STATUS = 8'hAB;
    localparam logic [7:0] ADDR_CONTROL = 8'hAC;
    localparam logic [7:0] ADDR_PRESCALE = 8'hAD;
    localparam logic [7:0] ADDR_COUNTER = 8'hAE;

    // ------------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------------
    localparam logic [8:0] RAM_DEPTH = 9'h100;
    localparam logic [7:0] RAM_LAST = 8'hFF;
    localparam logic [7:0] RX_SIZE_MAX = 8'hB6;
    localparam logic [7:0] RX_SIZE_RESET = 8'hB6;
    localparam logic [3:0] PRESCALE_RESET = 4'h0;
    localparam logic [3:0] PRESCALE_EXP_MAX = 4'h8;
    localparam logic [7:0] COUNTER_RESET = 8'hD8;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_STORED_MASK = 8'h1C;
    localparam logic [2:0] LAST_DATA_BIT = 3'h7;
    localparam logic [7:0] PREAMBLE_ZERO = 8'h00;
    localparam logic [7:0] PREAMBLE_END = 8'hFF;
    localparam logic [1:0] PREAMBLE_ZEROS_SEEN = 2'h2;
    localparam logic [2:0] WAKE_EDGES = 3'h5;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] exp;
        logic [7:0] count;
    } baud_t;

    typedef struct packed {
        logic [2:0] reserved;
        logic [1:0] tx_stop_extra;
        logic rx_two_stops;
        logic wake_enable_bit;
        logic start_frame;
    } control_t;

    typedef struct packed {
        logic tx_full;
        logic rx_empty;
        logic filter_armed;
        logic wake_request;
        logic rx_busy;
        logic tx_busy;
        logic overrun;
        logic frame_error;
    } status_t;

    typedef struct packed {
        logic frame_error;
        logic [7:0] data;
    } rx_result_t;

    // Terminal count of the power-of-two prescaler; exponents above 8 act as 8.
    function automatic logic [7:0] prescale_limit(input logic [3:0] exp);
        logic [8:0] factor;
        factor = 9'h001 << ((exp > PRESCALE_EXP_MAX) ? PRESCALE_EXP_MAX : exp);
        return 8'(factor - 9'h001);
    endfunction

endpackage

// ---- rtl/uart_rx_engine.sv ----
`timescale 1ns/1ps
`default_nettype none

module uart_rx_engine (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Configuration
    input wire fast_uart_pkg::baud_t baud,
    input wire logic two_stops,
    // Serial side
    input wire logic line,
    // Received byte and state
    output logic valid,
    output fast_uart_pkg::rx_result_t result,
    output logic busy
);

    enum {IDLE, START, DATA, STOP} state;
    logic [7:0] pre_cnt;
    logic [7:0] tick_cnt;
    logic [7:0] shift;
    logic [2:0] bit_idx;
    logic stop_left;
    logic stop_bad;

    wire logic idle = state == IDLE;
    wire logic pre_tick = pre_cnt == fast_uart_pkg::prescale_limit(baud.exp); // see [RULE_10]
    wire logic bit_end = pre_tick && tick_cnt == baud.count; // see [RULE_11]
    wire logic mid = pre_tick && tick_cnt == (baud.count >> 1); // see [RULE_20]

    // Counters stay cleared while idle so that bit timing starts at the falling edge.
    always_ff @(posedge clk) begin
        if (reset || idle || pre_tick) begin
            pre_cnt <= 8'h00;
        end else begin
            pre_cnt <= pre_cnt + 8'h01;
        end
        if (reset || idle || bit_end) begin
            tick_cnt <= 8'h00;
        end else if (pre_tick) begin
            tick_cnt <= tick_cnt + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= IDLE;
            valid <= 1'b0;
            result <= '0;
            busy <= 1'b0;
            shift <= 8'h00;
            bit_idx <= 3'h0;
            stop_left <= 1'b0;
            stop_bad <= 1'b0;
        end else begin
            valid <= 1'b0;
            unique case (state)
                IDLE: begin
                    busy <= 1'b0;
                    if (!line) begin
                        busy <= 1'b1;
                        state <= START; // see [RULE_04]
                    end
                end
                START: begin
                    if (mid && line) begin
                        state <= IDLE; // see [RULE_21]
                    end else if (bit_end) begin
                        bit_idx <= 3'h0;
                        state <= DATA;
                    end
                end
                DATA: begin
                    if (mid) begin
                        shift <= {line, shift[7:1]}; // see [RULE_05]
                    end
                    if (bit_end && bit_idx == fast_uart_pkg::LAST_DATA_BIT) begin
                        stop_left <= two_stops; // see [RULE_06]
                        stop_bad <= 1'b0;
                        state <= STOP;
                    end else if (bit_end) begin
                        bit_idx <= bit_idx + 3'h1;
                    end
                end
                STOP: begin
                    // The last stop bit ends at its middle so a following start edge is seen.
                    if (mid && !stop_left) begin
                        valid <= 1'b1;
                        result <= '{frame_error: stop_bad || !line, data: shift}; // see [RULE_06], [RULE_19]
                        state <= IDLE;
                    end else if (mid) begin
                        stop_bad <= !line;
                    end else if (bit_end) begin
                        stop_left <= 1'b0;
                    end
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ---- rtl/uart_tx_engine.sv ----
`timescale 1ns/1ps
`default_nettype none

module uart_tx_engine (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Configuration
    input wire fast_uart_pkg::baud_t baud,
    input wire logic [1:0] stop_extra,
    // Byte request
    input wire logic start,
    input wire logic [7:0] data,
    // Serial side and state
    output logic line,
    output logic busy
);

    enum {IDLE, START, DATA, STOP} state;
    logic [7:0] pre_cnt;
    logic [7:0] tick_cnt;
    logic [7:0] shift;
    logic [2:0] bit_idx;
    logic [1:0] stop_left;

    wire logic pre_tick = pre_cnt == fast_uart_pkg::prescale_limit(baud.exp); // see [RULE_10]
    wire logic bit_end = pre_tick && tick_cnt == baud.count; // see [RULE_11]
    wire logic idle = state == IDLE;

    always_ff @(posedge clk) begin
        if (reset || idle || pre_tick) begin
            pre_cnt <= 8'h00;
        end else begin
            pre_cnt <= pre_cnt + 8'h01;
        end
        if (reset || idle || bit_end) begin
            tick_cnt <= 8'h00;
        end else if (pre_tick) begin
            tick_cnt <= tick_cnt + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= IDLE;
            line <= 1'b1;
            busy <= 1'b0;
            shift <= 8'h00;
            bit_idx <= 3'h0;
            stop_left <= 2'h0;
        end else begin
            unique case (state)
                IDLE: begin
                    if (start) begin
                        shift <= data;
                        line <= 1'b0;
                        busy <= 1'b1;
                        state <= START;
                    end
                end
                START: begin
                    if (bit_end) begin
                        line <= shift[0]; // see [RULE_05]
                        bit_idx <= 3'h0;
                        state <= DATA;
                    end
                end
                DATA: begin
                    if (bit_end && bit_idx == fast_uart_pkg::LAST_DATA_BIT) begin
                        line <= 1'b1;
                        stop_left <= stop_extra; // see [RULE_07]
                        state <= STOP;
                    end else if (bit_end) begin
                        shift <= shift >> 1;
                        line <= shift[1];
                        bit_idx <= bit_idx + 3'h1;
                    end
                end
                STOP: begin
                    if (bit_end && stop_left == 2'h0) begin
                        busy <= 1'b0;
                        state <= IDLE;
                    end else if (bit_end) begin
                        stop_left <= stop_left - 2'h1;
                    end
                end
            endcase
        end
    end

endmodule

`default_nettype wire
